/* shared/lrs_pkg.sv */
// Constants shared by the regulator state logic, its timers and register map
`default_nettype none
package lrs_pkg;
	// ----------------------------------------------------------------
	// Regulator states, Gray coded along idle -> start -> run
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LRS_IDLE  = 2'h0,
		LRS_START = 2'h1,
		LRS_RUN   = 2'h3
	} lrs_state_e;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 50;
	localparam int T_ON_MAX_NS    = 10000;   // Longest switch on-time
	localparam int T_OFF_MAX_NS   = 100000;  // Longest wait for a valley
	localparam int CNT_W          = 11;
	localparam logic [CNT_W-1:0] ON_MAX_CYC  = CNT_W'(T_ON_MAX_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] OFF_MAX_CYC = CNT_W'(T_OFF_MAX_NS / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] CNT_ONE     = 11'h001;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and fields
	// ----------------------------------------------------------------
	localparam int AW = 8;
	localparam logic [AW-1:0] REG_CTRL     = 8'h00;
	localparam logic [AW-1:0] REG_STATUS   = 8'h04;
	localparam logic [AW-1:0] REG_IRQ_STAT = 8'h08;
	localparam logic [AW-1:0] REG_IRQ_MASK = 8'h0C;
	localparam int CTRL_VALLEY_EN = 0;
	localparam logic CTRL_RST     = 1'h1;
	localparam int NEVT           = 4;
	localparam logic [NEVT-1:0] MASK_RST = 4'h0;
	localparam int EVT_RUN     = 0;  // Entered run
	localparam int EVT_DROP    = 1;  // Fell back to idle
	localparam int EVT_MAX_ON  = 2;  // On-time cut by the limit
	localparam int EVT_MAX_OFF = 3;  // Cycle restarted without valley
	localparam int ST_STATE    = 0;  // Two bits
	localparam int ST_INHIBIT  = 2;
	localparam int ST_HEADROOM = 3;
	localparam int ST_GATE     = 4;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ----------------------------------------------------------------
	// Synchronised input lanes
	// ----------------------------------------------------------------
	localparam int NSYNC      = 6;
	localparam int IN_VDD_UV  = 0;
	localparam int IN_BUS_UV  = 1;
	localparam int IN_BUS_OV  = 2;
	localparam int IN_OTEMP   = 3;
	localparam int IN_HEADROOM = 4;
	localparam int IN_POL_NEG = 5;
endpackage : lrs_pkg
`default_nettype wire

/* core/lrs_sync.sv */
// Two-flop synchroniser for a group of independent comparator levels
`default_nettype none
module lrs_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Levels
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_ff;

	// First stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_ff <= '0;
			dout    <= '0;
		end else begin
			meta_ff <= din;
			dout    <= meta_ff;
		end
	end
endmodule // lrs_sync
`default_nettype wire

/* core/lrs_switch_timer.sv */
// Switch cycle timing: valley strobe, maximum on-time and maximum off-time
`default_nettype none
module lrs_switch_timer (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Control
	input  wire logic switch_enable,
	input  wire logic valley_enable,
	input  wire logic on_time_done,
	input  wire logic polarity_negative,
	// Results
	output logic      gate_on_ff,
	output logic      valley_strobe_ff,
	output logic      max_on_evt_ff,
	output logic      max_off_evt_ff
);
	logic                         armed_ff;
	logic [lrs_pkg::CNT_W-1:0]    cnt_ff;
	logic                         on_limit;
	logic                         off_limit;

	assign on_limit  = cnt_ff == lrs_pkg::ON_MAX_CYC - lrs_pkg::CNT_ONE;
	assign off_limit = cnt_ff == lrs_pkg::OFF_MAX_CYC - lrs_pkg::CNT_ONE;

	// Valley detector: arm on negative current, strobe once on return
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			armed_ff         <= 1'b0;
			valley_strobe_ff <= 1'b0;
		end else begin
			valley_strobe_ff <= armed_ff && !polarity_negative;
			if (polarity_negative)
				armed_ff <= 1'b1;
			else if (armed_ff)
				armed_ff <= 1'b0;
		end
	end

	// On/off phase timer; held in off while switching is disabled
	always_ff @(posedge aclk) begin
		if (!aresetn || !switch_enable) begin
			gate_on_ff     <= 1'b0;
			cnt_ff         <= '0;
			max_on_evt_ff  <= 1'b0;
			max_off_evt_ff <= 1'b0;
		end else begin
			max_on_evt_ff  <= 1'b0;
			max_off_evt_ff <= 1'b0;
			if (gate_on_ff) begin
				if (on_time_done || on_limit) begin
					gate_on_ff    <= 1'b0;
					cnt_ff        <= '0;
					max_on_evt_ff <= on_limit && !on_time_done;
				end else begin
					cnt_ff <= cnt_ff + lrs_pkg::CNT_ONE;
				end
			end else if ((valley_strobe_ff && valley_enable) || off_limit) begin
				gate_on_ff     <= 1'b1;
				cnt_ff         <= '0;
				max_off_evt_ff <= off_limit && !(valley_strobe_ff && valley_enable);
			end else begin
				cnt_ff <= cnt_ff + lrs_pkg::CNT_ONE;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_went_negative;
		polarity_negative ##1 !polarity_negative;
	endsequence

	chk_valley_one_strobe: assert property (s_went_negative |=> valley_strobe_ff ##1 !valley_strobe_ff)
		else $error("valley strobe missing or not single");
	chk_on_time_cap: assert property (gate_on_ff && switch_enable && on_limit |=> !gate_on_ff)
		else $error("switch on-time exceeded limit");
	chk_off_time_cap: assert property (!gate_on_ff && switch_enable && off_limit |=> gate_on_ff)
		else $error("off-time timer did not restart cycle");
endmodule // lrs_switch_timer
`default_nettype wire

/* core/lrs_regulator.sv */
// Regulator state logic of the LED driver with its AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
// Operation
// - At power-up the state machine starts in idle.
// - Idle: no switching, linear supply, 20% reference, amplifier grounded.
// - Stay in idle while inhibit is asserted.
// - Leave idle for start once inhibit deasserts.
// - Hold start until headroom-ok reports nominal headroom.
// - Start: switching on, switching supply, 20% reference, amplifier released, ramp source on.
// - From start go to run on headroom-ok, back to idle on inhibit.
// - Run: switching on, switching supply, 100% reference, amplifier regulating.
// - In run, return to idle whenever inhibit asserts.
// - In run, headroom-ok is ignored.
// - Valley detector arms on negative current, strobes once on return positive.
// - Inhibit is the OR of four undervoltage, overvoltage and temperature flags.
// - Off-time timer restarts switching after about 100 us without a valley.
// - On-time timer ends the switch on-time at about 10 us.
module lrs_regulator (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Comparator levels
	input  wire logic        supply_undervoltage,
	input  wire logic        bus_undervoltage,
	input  wire logic        bus_overvoltage,
	input  wire logic        die_overtemperature,
	input  wire logic        headroom_level_ok,
	input  wire logic        polarity_negative,
	input  wire logic        on_time_done,
	// Power stage controls
	output logic             boost_enable_ff,
	output logic             supply_switching_ff,
	output logic             led_ref_full_ff,
	output logic             amp_ground_ff,
	output logic             amp_ramp_source_ff,
	output logic             amp_regulate_ff,
	output logic             gate_on_ff,
	output logic             valley_strobe_ff,
	// Interrupt
	output logic             irq_ff,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [lrs_pkg::NSYNC-1:0] raw_in;
	logic [lrs_pkg::NSYNC-1:0] sync_in;
	logic                      inhibit_ff;
	logic [1:0]                sync_ok_ff;
	lrs_pkg::lrs_state_e       state_ff;
	lrs_pkg::lrs_state_e       nxt_state;
	logic                      valley_en_ff;
	logic [lrs_pkg::NEVT-1:0]  mask_ff;
	logic [lrs_pkg::NEVT-1:0]  irq_stat_ff;
	logic [lrs_pkg::NEVT-1:0]  nxt_irq_stat;
	logic [lrs_pkg::NEVT-1:0]  evt;
	logic                      max_on_evt;
	logic                      max_off_evt;
	logic                      aw_got_ff;
	logic                      w_got_ff;
	logic [7:0]                aw_addr_ff;
	logic [31:0]               w_data_ff;
	logic                      w_lane0_ff;
	logic                      aw_take;
	logic                      w_take;
	logic                      ar_take;
	logic                      do_wr;
	logic                      nxt_aw_got;
	logic                      nxt_w_got;
	logic                      nxt_rvalid;

	// Register decode, shared by read and write paths
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = a == lrs_pkg::REG_CTRL || a == lrs_pkg::REG_STATUS ||
			a == lrs_pkg::REG_IRQ_STAT || a == lrs_pkg::REG_IRQ_MASK;
	endfunction

	// ----------------------------------------------------------------
	// Input synchronisation and inhibit
	// ----------------------------------------------------------------
	assign raw_in = {polarity_negative, headroom_level_ok, die_overtemperature,
		bus_overvoltage, bus_undervoltage, supply_undervoltage};

	// Comparators are asynchronous to the logic clock
	lrs_sync #(.W(lrs_pkg::NSYNC)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (raw_in),
		.dout    (sync_in)
	);

	// Any protection flag holds the regulator off; the synchroniser's reset zeros are not trusted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_ok_ff <= 2'h0;
			inhibit_ff <= 1'b1;
		end else begin
			sync_ok_ff <= {sync_ok_ff[0], 1'b1};
			inhibit_ff <= !sync_ok_ff[1] || |sync_in[lrs_pkg::IN_OTEMP:lrs_pkg::IN_VDD_UV];
		end
	end

	// ----------------------------------------------------------------
	// Regulator state machine
	// ----------------------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			lrs_pkg::LRS_IDLE: begin
				if (!inhibit_ff)
					nxt_state = lrs_pkg::LRS_START;
			end
			lrs_pkg::LRS_START: begin
				if (inhibit_ff)
					nxt_state = lrs_pkg::LRS_IDLE;
				else if (sync_in[lrs_pkg::IN_HEADROOM])
					nxt_state = lrs_pkg::LRS_RUN;
			end
			lrs_pkg::LRS_RUN: begin
				// Headroom dips are normal ripple; only inhibit leaves run
				if (inhibit_ff)
					nxt_state = lrs_pkg::LRS_IDLE;
			end
			default: nxt_state = lrs_pkg::LRS_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			state_ff <= lrs_pkg::LRS_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Stage controls follow the next state so they line up with state_ff
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boost_enable_ff     <= 1'b0;
			supply_switching_ff <= 1'b0;
			led_ref_full_ff     <= 1'b0;
			amp_ground_ff       <= 1'b1;
			amp_ramp_source_ff  <= 1'b0;
			amp_regulate_ff     <= 1'b0;
		end else begin
			boost_enable_ff     <= nxt_state != lrs_pkg::LRS_IDLE;
			supply_switching_ff <= nxt_state != lrs_pkg::LRS_IDLE;
			led_ref_full_ff     <= nxt_state == lrs_pkg::LRS_RUN;
			amp_ground_ff       <= nxt_state == lrs_pkg::LRS_IDLE;
			amp_ramp_source_ff  <= nxt_state == lrs_pkg::LRS_START;
			amp_regulate_ff     <= nxt_state == lrs_pkg::LRS_RUN;
		end
	end

	// ----------------------------------------------------------------
	// Switching cycle timing
	// ----------------------------------------------------------------
	lrs_switch_timer u_timer (
		.aclk              (aclk),
		.aresetn           (aresetn),
		.switch_enable     (boost_enable_ff),
		.valley_enable     (valley_en_ff),
		.on_time_done      (on_time_done),
		.polarity_negative (sync_in[lrs_pkg::IN_POL_NEG]),
		.gate_on_ff        (gate_on_ff),
		.valley_strobe_ff  (valley_strobe_ff),
		.max_on_evt_ff     (max_on_evt),
		.max_off_evt_ff    (max_off_evt)
	);

	// ----------------------------------------------------------------
	// Events and interrupt
	// ----------------------------------------------------------------
	always_comb begin
		evt                        = '0;
		evt[lrs_pkg::EVT_RUN]      = nxt_state == lrs_pkg::LRS_RUN && state_ff != lrs_pkg::LRS_RUN;
		evt[lrs_pkg::EVT_DROP]     = nxt_state == lrs_pkg::LRS_IDLE && state_ff != lrs_pkg::LRS_IDLE;
		evt[lrs_pkg::EVT_MAX_ON]   = max_on_evt;
		evt[lrs_pkg::EVT_MAX_OFF]  = max_off_evt;
		// Read clears, but an event in the same cycle survives
		nxt_irq_stat = irq_stat_ff;
		if (ar_take && s_axi_araddr == lrs_pkg::REG_IRQ_STAT)
			nxt_irq_stat = '0;
		nxt_irq_stat = nxt_irq_stat | evt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_ff <= '0;
			irq_ff      <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
			irq_ff      <= |(nxt_irq_stat & mask_ff);
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	assign aw_take    = s_axi_awvalid && s_axi_awready;
	assign w_take     = s_axi_wvalid && s_axi_wready;
	assign do_wr      = aw_got_ff && w_got_ff && !s_axi_bvalid;
	assign nxt_aw_got = (aw_got_ff && !do_wr) || aw_take;
	assign nxt_w_got  = (w_got_ff && !do_wr) || w_take;

	// Address and data are taken in either order, one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_ff     <= 1'b0;
			w_got_ff      <= 1'b0;
			aw_addr_ff    <= '0;
			w_data_ff     <= '0;
			w_lane0_ff    <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= lrs_pkg::RESP_OKAY;
		end else begin
			aw_got_ff     <= nxt_aw_got;
			w_got_ff      <= nxt_w_got;
			s_axi_awready <= !nxt_aw_got;
			s_axi_wready  <= !nxt_w_got;
			if (aw_take)
				aw_addr_ff <= s_axi_awaddr;
			if (w_take) begin
				w_data_ff  <= s_axi_wdata;
				w_lane0_ff <= s_axi_wstrb[0];
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= is_mapped(aw_addr_ff) ? lrs_pkg::RESP_OKAY : lrs_pkg::RESP_DECERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Writable registers hold only byte lane 0
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valley_en_ff <= lrs_pkg::CTRL_RST;
			mask_ff      <= lrs_pkg::MASK_RST;
		end else if (do_wr && w_lane0_ff) begin
			if (aw_addr_ff == lrs_pkg::REG_CTRL)
				valley_en_ff <= w_data_ff[lrs_pkg::CTRL_VALLEY_EN];
			if (aw_addr_ff == lrs_pkg::REG_IRQ_MASK)
				mask_ff <= w_data_ff[lrs_pkg::NEVT-1:0];
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	assign ar_take    = s_axi_arvalid && s_axi_arready;
	assign nxt_rvalid = (s_axi_rvalid && !s_axi_rready) || ar_take;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= lrs_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !nxt_rvalid;
			s_axi_rvalid  <= nxt_rvalid;
			if (ar_take) begin
				s_axi_rdata <= '0;
				s_axi_rresp <= is_mapped(s_axi_araddr) ? lrs_pkg::RESP_OKAY : lrs_pkg::RESP_DECERR;
				case (s_axi_araddr)
					lrs_pkg::REG_CTRL:
						s_axi_rdata[lrs_pkg::CTRL_VALLEY_EN] <= valley_en_ff;
					lrs_pkg::REG_STATUS: begin
						s_axi_rdata[lrs_pkg::ST_STATE+:2]   <= state_ff;
						s_axi_rdata[lrs_pkg::ST_INHIBIT]    <= inhibit_ff;
						s_axi_rdata[lrs_pkg::ST_HEADROOM]   <= sync_in[lrs_pkg::IN_HEADROOM];
						s_axi_rdata[lrs_pkg::ST_GATE]       <= gate_on_ff;
					end
					lrs_pkg::REG_IRQ_STAT:
						s_axi_rdata[lrs_pkg::NEVT-1:0] <= irq_stat_ff;
					lrs_pkg::REG_IRQ_MASK:
						s_axi_rdata[lrs_pkg::NEVT-1:0] <= mask_ff;
					default: s_axi_rdata <= '0;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_reset_idle: assert property (disable iff (1'b0) !aresetn |=> state_ff == lrs_pkg::LRS_IDLE)
		else $error("state not idle after reset");
	chk_idle_outputs: assert property (state_ff == lrs_pkg::LRS_IDLE |->
		!boost_enable_ff && !supply_switching_ff && !led_ref_full_ff && amp_ground_ff)
		else $error("idle outputs wrong");
	chk_idle_hold: assert property (state_ff == lrs_pkg::LRS_IDLE && inhibit_ff |=>
		state_ff == lrs_pkg::LRS_IDLE)
		else $error("left idle under inhibit");
	chk_idle_exit: assert property (state_ff == lrs_pkg::LRS_IDLE && !inhibit_ff |=>
		state_ff == lrs_pkg::LRS_START && boost_enable_ff)
		else $error("idle did not move to start");
	chk_start_wait: assert property (state_ff == lrs_pkg::LRS_START && !inhibit_ff &&
		!sync_in[lrs_pkg::IN_HEADROOM] |=> state_ff == lrs_pkg::LRS_START)
		else $error("start left without headroom");
	chk_start_outputs: assert property (state_ff == lrs_pkg::LRS_START |-> boost_enable_ff &&
		supply_switching_ff && !led_ref_full_ff && !amp_ground_ff && amp_ramp_source_ff)
		else $error("start outputs wrong");
	chk_start_exits: assert property (state_ff == lrs_pkg::LRS_START && !inhibit_ff &&
		sync_in[lrs_pkg::IN_HEADROOM] |=> state_ff == lrs_pkg::LRS_RUN && led_ref_full_ff)
		else $error("start did not enter run");
	chk_run_outputs: assert property (state_ff == lrs_pkg::LRS_RUN |-> boost_enable_ff &&
		led_ref_full_ff && amp_regulate_ff && !amp_ramp_source_ff)
		else $error("run outputs wrong");
	chk_run_stop: assert property (state_ff != lrs_pkg::LRS_IDLE && inhibit_ff |=>
		state_ff == lrs_pkg::LRS_IDLE)
		else $error("inhibit did not force idle");
	chk_run_ignore_hv: assert property (state_ff == lrs_pkg::LRS_RUN && !inhibit_ff |=>
		state_ff == lrs_pkg::LRS_RUN)
		else $error("run left without inhibit");
	chk_inhibit_or: assert property ($past(sync_ok_ff[1]) |->
		(|$past(raw_in[lrs_pkg::IN_OTEMP:lrs_pkg::IN_VDD_UV], 3)) == inhibit_ff)
		else $error("inhibit does not follow flags");
endmodule // lrs_regulator
`default_nettype wire

/* verification/lrs_stage_model.sv */
// Behavioural boost power stage: on-time modulator and inductor polarity comparator
`default_nettype none
module lrs_stage_model (
	// Clock
	input  wire logic aclk,
	// Stage control
	input  wire logic gate_on_ff,
	input  wire logic modulator_en,
	input  wire logic ringing_en,
	// Comparator outputs
	output var logic  on_time_done,
	output var logic  polarity_negative
);
	timeunit 1ns;
	timeprecision 1ns;
	int on_cnt = 0;
	int off_cnt = 0;
	// ----------------------------------------------------------------
	// Switching cycle
	// ----------------------------------------------------------------
	// Modulator ends the on-time after 20 cycles; the drain rings negative for 4 cycles
	// A disabled modulator lets the max on-time limit act, disabled ringing starves the valley detector
	always @(posedge aclk) begin
		on_cnt <= gate_on_ff ? on_cnt + 1 : 0;
		off_cnt <= gate_on_ff ? 0 : off_cnt + 1;
		on_time_done <= modulator_en && gate_on_ff && on_cnt >= 20;
		polarity_negative <= ringing_en && !gate_on_ff && off_cnt >= 10 && off_cnt < 14;
	end
endmodule // lrs_stage_model
`default_nettype wire

/* verification/lrs_regulator_bench.sv */
// Self-checking bench for the regulator state logic over AXI4-Lite
`default_nettype none
module lrs_regulator_bench;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [3:0] flags = 4'hF;
	logic headroom = 1'b0, mod_en = 1'b1, ring_en = 1'b1, pol_neg, otd;
	logic boost, supply, ref_full, amp_gnd, ramp, regul, gate, strobe, irq;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int failures = 0, checked = 0, strobes = 0, strobe_base = 0;
	logic [31:0] rd;
	logic [1:0] rsp;
	lrs_regulator dut (.aclk(aclk), .aresetn(aresetn), .supply_undervoltage(flags[0]),
		.bus_undervoltage(flags[1]), .bus_overvoltage(flags[2]), .die_overtemperature(flags[3]),
		.headroom_level_ok(headroom), .polarity_negative(pol_neg), .on_time_done(otd),
		.boost_enable_ff(boost), .supply_switching_ff(supply), .led_ref_full_ff(ref_full),
		.amp_ground_ff(amp_gnd), .amp_ramp_source_ff(ramp), .amp_regulate_ff(regul), .gate_on_ff(gate),
		.valley_strobe_ff(strobe), .irq_ff(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	lrs_stage_model stage (.aclk(aclk), .gate_on_ff(gate), .modulator_en(mod_en), .ringing_en(ring_en),
		.on_time_done(otd), .polarity_negative(pol_neg));
	// Clock and strobe counter
	initial begin
		forever #25 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		if (strobe === 1'b1) strobes <= strobes + 1;
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Write: address and data offered together, each released once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		r = bresp;
		bready <= 1'b0;
		chk("write taken before answer", 32'h0, {31'h0, awvalid | wvalid});
	endtask
	// Only the watchdog ends a wait for an answer
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		chk("read taken before answer", 32'h0, {31'h0, arvalid});
	endtask
	// Control outputs packed as boost, supply, full ref, ground, ramp, regulate
	task automatic chk_ctl(input string name, input logic [5:0] exp);
		chk(name, {26'h0, exp}, {26'h0, boost, supply, ref_full, amp_gnd, ramp, regul});
	endtask
	task automatic chk_state(input string name, input lrs_pkg::lrs_state_e s);
		axi_rd(lrs_pkg::REG_STATUS, rd, rsp);
		chk(name, {30'h0, s}, {30'h0, rd[1:0]});
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic complete_run;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		wait_cyc(6);
		aresetn <= 1'b1;
		wait_cyc(8);
		chk_ctl("idle controls", 6'b000100);
		axi_rd(lrs_pkg::REG_CTRL, rd, rsp);
		chk("ctrl reset", 32'h1, rd);
		axi_rd(lrs_pkg::REG_IRQ_MASK, rd, rsp);
		chk("mask reset", 32'h0, rd);
		// A false start while the flags are still high would leave a drop event
		axi_rd(lrs_pkg::REG_IRQ_STAT, rd, rsp);
		chk("no event after reset", 32'h0, rd);
		axi_rd(8'h10, rd, rsp);
		chk("unmapped read", {30'h0, lrs_pkg::RESP_DECERR}, {rd[29:0], rsp});
		axi_wr(8'h10, 32'h1, rsp);
		chk("unmapped write", {30'h0, lrs_pkg::RESP_DECERR}, {30'h0, rsp});
		axi_wr(lrs_pkg::REG_IRQ_MASK, 32'hF, rsp);
		// A write without byte lane 0 is answered but ignored
		wstrb <= 4'hE;
		axi_wr(lrs_pkg::REG_IRQ_MASK, 32'h0, rsp);
		wstrb <= 4'hF;
		chk("lane write resp", {30'h0, lrs_pkg::RESP_OKAY}, {30'h0, rsp});
		axi_rd(lrs_pkg::REG_IRQ_MASK, rd, rsp);
		chk("lane write ignored", 32'hF, rd);
		// Each inhibit source alone holds idle
		for (int i = 0; i < 4; i++) begin
			flags <= 4'h1 << i;
			wait_cyc(10);
			chk_state("inhibit holds idle", lrs_pkg::LRS_IDLE);
		end
		flags <= 4'h0;
		wait_cyc(10);
		chk_ctl("start controls", 6'b110010);
		chk_state("start held", lrs_pkg::LRS_START);
		flags <= 4'h8;
		wait_cyc(8);
		chk_state("start to idle", lrs_pkg::LRS_IDLE);
		flags <= 4'h0;
		wait_cyc(8);
		axi_rd(lrs_pkg::REG_IRQ_STAT, rd, rsp);
		headroom <= 1'b1;
		wait_cyc(8);
		chk_ctl("run controls", 6'b111001);
		chk("irq level", 32'h1, {31'h0, irq});
		axi_rd(lrs_pkg::REG_IRQ_STAT, rd, rsp);
		chk("run event", 32'h1, rd & 32'h1);
		// Headroom lost and toggling in run changes nothing
		headroom <= 1'b0;
		wait_cyc(20);
		headroom <= 1'b1;
		wait_cyc(3);
		headroom <= 1'b0;
		wait_cyc(20);
		chk_state("run ignores headroom", lrs_pkg::LRS_RUN);
		// No ringing before the first cycle, so the off-time timer must start switching
		strobe_base = strobes;
		wait_cyc(2100);
		chk("valley strobes", 32'h1, {31'h0, strobes > strobe_base});
		mod_en <= 1'b0;
		wait_cyc(300);
		axi_rd(lrs_pkg::REG_IRQ_STAT, rd, rsp);
		chk("max on event", 32'h4, rd & 32'h4);
		chk("first cycle by off timer", 32'h8, rd & 32'h8);
		mod_en <= 1'b1;
		axi_wr(lrs_pkg::REG_CTRL, 32'h0, rsp);
		wait_cyc(2300);
		axi_rd(lrs_pkg::REG_IRQ_STAT, rd, rsp);
		chk("max off event", 32'h8, rd & 32'h8);
		flags <= 4'h4;
		wait_cyc(8);
		chk_ctl("run to idle", 6'b000100);
		axi_rd(lrs_pkg::REG_IRQ_STAT, rd, rsp);
		chk("drop event", 32'h2, rd & 32'h2);
		wait_cyc(3);
		chk("irq cleared", 32'h0, {31'h0, irq});
		complete_run();
	end
	// Watchdog well beyond the expected 4900 cycles or so
	initial begin
		#(20000 * 50);
		failures++;
		complete_run();
	end
endmodule // lrs_regulator_bench
`default_nettype wire
